/* File: logic/rbcs_pkg.sv */
// Package of constants and carrier types for the reset, boot and clock select block.
package rbcs_pkg;

  // Speed select pin codes.
  localparam logic [1:0] SPEED_RESERVED = 2'h0;
  localparam logic [1:0] SPEED_BYPASS   = 2'h1;
  localparam logic [1:0] SPEED_X2       = 2'h2;
  localparam logic [1:0] SPEED_X3       = 2'h3;

  // Ratio readback values.
  localparam logic [1:0] RATIO_BYPASS = 2'h1;
  localparam logic [1:0] RATIO_X2     = 2'h2;
  localparam logic [1:0] RATIO_X3     = 2'h3;
  localparam logic [1:0] RATIO_RESET  = 2'h0;

  // First fetch address after reset when booting from ROM.
  localparam logic [31:0] BOOT_ADDR = 32'h07FFFFFE;

  // Cycles spent in INIT, after the one HELD cycle that follows the synchronised release; the clocks stay stopped through both.
  localparam logic [3:0] INIT_CYCLES = 4'h8;

  // INIT count from which the three strap stages hold real samples again.
  localparam logic [3:0] STRAP_FILL = 4'h2;

  typedef enum logic [1:0] {
    RBCS_HELD,
    RBCS_INIT,
    RBCS_RUN,
    RBCS_DOWN
  } rbcs_state_t;

  // Clock control outputs that travel together.
  typedef struct packed {
    logic       clk_run;
    logic       pll_enable;
    logic       pll_bypass_mode;
    logic [1:0] pll_ratio_readback;
  } rbcs_clk_ctl_t;

  // Registered state of the block, apart from the two reset synchroniser flops.
  typedef struct packed {
    rbcs_state_t   state;
    logic [3:0]    init_cnt;
    logic [1:0]    speed_a;
    logic [1:0]    speed_b;
    logic [1:0]    speed_c;
    logic          code_reserved;
    rbcs_clk_ctl_t ctl;
    logic          sys_reset_n;
    logic          boot_start;
  } rbcs_regs_t;

endpackage

/* File: logic/rbcs_top.sv */
// Reset release, boot start and processor clock selection for the system services block.
`timescale 1ns/1ps
module rbcs_top (
  // Clock and board reset
  input  wire logic                   clk,
  input  wire logic                   nrst,
  // Strap pins
  input  wire logic [1:0]             speed_sel_pins,
  // Power control
  input  wire logic                   power_down_req,
  // Reset and boot outputs
  output logic                        sys_reset_n,
  output logic                        boot_start,
  output logic [31:0]                 boot_fetch_addr,
  // Clock control outputs
  output rbcs_pkg::rbcs_clk_ctl_t     clk_ctl,
  output logic                        speed_reserved
);

  rbcs_pkg::rbcs_regs_t r_reg;
  rbcs_pkg::rbcs_regs_t r_next;
  logic                 rst_meta_reg;
  logic                 rst_sync_reg;
  logic                 stages_full;

  // Decode the filtered speed code into the clock controls.
  function automatic rbcs_pkg::rbcs_clk_ctl_t decode_speed(input logic [1:0] code,
                                                            input logic       run);
    rbcs_pkg::rbcs_clk_ctl_t c;
    c.clk_run            = run;
    c.pll_enable         = 1'b0;
    c.pll_bypass_mode    = 1'b0;
    c.pll_ratio_readback = rbcs_pkg::RATIO_RESET;
    case (code)
      rbcs_pkg::SPEED_BYPASS: begin
        c.pll_bypass_mode    = 1'b1;
        c.pll_ratio_readback = rbcs_pkg::RATIO_BYPASS;
      end
      rbcs_pkg::SPEED_X2: begin
        c.pll_enable         = run;
        c.pll_ratio_readback = rbcs_pkg::RATIO_X2;
      end
      rbcs_pkg::SPEED_X3: begin
        c.pll_enable         = run;
        c.pll_ratio_readback = rbcs_pkg::RATIO_X3;
      end
      default: begin
        c.clk_run = 1'b0;
      end
    endcase
    return c;
  endfunction

  // two-flop release
  // The pin asserts the internal reset at once; only its release waits two edges.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  always_comb begin
    r_next = r_reg;
    r_next.boot_start = 1'b0;
    // Straps pass three flops; a change counts once the last two agree.
    // A one-cycle glitch never sits in both of the last two stages at once,
    // so it is never decoded.
    r_next.speed_a = speed_sel_pins;
    r_next.speed_b = r_reg.speed_a;
    r_next.speed_c = r_reg.speed_b;
    case (r_reg.state)
      rbcs_pkg::RBCS_HELD: begin
        r_next.state    = rbcs_pkg::RBCS_INIT;
        r_next.init_cnt = 4'h0;
      end
      rbcs_pkg::RBCS_INIT: begin
        r_next.init_cnt = r_reg.init_cnt + 4'h1;
        if (r_reg.init_cnt == rbcs_pkg::INIT_CYCLES - 4'h1) begin
          r_next.state       = rbcs_pkg::RBCS_RUN;
          r_next.sys_reset_n = 1'b1;
          r_next.boot_start  = 1'b1;
        end
      end
      rbcs_pkg::RBCS_RUN: begin
        if (power_down_req) begin
          r_next.state = rbcs_pkg::RBCS_DOWN;
        end
      end
      rbcs_pkg::RBCS_DOWN: begin
        if (!power_down_req) begin
          r_next.state = rbcs_pkg::RBCS_RUN;
        end
      end
      default: begin
        r_next.state = rbcs_pkg::RBCS_HELD;
      end
    endcase
    if (stages_full && r_reg.speed_b == r_reg.speed_c) begin
      r_next.ctl           = decode_speed(r_reg.speed_c, r_next.state == rbcs_pkg::RBCS_RUN);
      r_next.code_reserved = r_reg.speed_c == rbcs_pkg::SPEED_RESERVED;
    end else begin
      // While the stages disagree the settled code stays; only the run gating follows.
      r_next.ctl.clk_run    = r_next.state == rbcs_pkg::RBCS_RUN && r_reg.ctl.clk_run;
      r_next.ctl.pll_enable = r_next.ctl.clk_run && r_reg.ctl.pll_enable;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst || !rst_sync_reg) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign sys_reset_n     = r_reg.sys_reset_n;
  assign boot_start      = r_reg.boot_start;
  assign boot_fetch_addr = rbcs_pkg::BOOT_ADDR;
  assign clk_ctl         = r_reg.ctl;
  assign speed_reserved  = r_reg.code_reserved;

  // The strap stages hold reset zeros until a few INIT edges have refilled them; a decode
  // before that would flag the reserved code for a moment after every release.
  assign stages_full = r_reg.state == rbcs_pkg::RBCS_RUN || r_reg.state == rbcs_pkg::RBCS_DOWN
                       || (r_reg.state == rbcs_pkg::RBCS_INIT
                           && r_reg.init_cnt >= rbcs_pkg::STRAP_FILL);

  chk_reset_stops_clk: assert property (@(posedge clk)
    !nrst |=> !clk_ctl.clk_run && !clk_ctl.pll_enable && !sys_reset_n)
    else $error("Clock or reset not forced while reset held.");

  chk_release_sync_delay: assert property (@(posedge clk)
    $rose(nrst) |-> !sys_reset_n [*3])
    else $error("Internal reset released without synchronisation.");

  chk_boot_after_init: assert property (@(posedge clk) disable iff (!nrst)
    boot_start |-> sys_reset_n && $rose(sys_reset_n) && boot_fetch_addr == 32'h07FFFFFE)
    else $error("Boot start not tied to reset release.");

  chk_ratio_bypass: assert property (@(posedge clk) disable iff (!nrst)
    clk_ctl.pll_bypass_mode |-> clk_ctl.pll_ratio_readback == 2'h1)
    else $error("Ratio readback not one in bypass.");

  chk_bypass_pll_off: assert property (@(posedge clk) disable iff (!nrst)
    clk_ctl.pll_bypass_mode |-> !clk_ctl.pll_enable)
    else $error("PLL enabled in bypass mode.");

  chk_power_down_off: assert property (@(posedge clk) disable iff (!nrst)
    r_reg.state == rbcs_pkg::RBCS_RUN && power_down_req |=> !clk_ctl.clk_run
      && !clk_ctl.pll_enable)
    else $error("Clock still running in power down.");

  chk_speed_x3: assert property (@(posedge clk) disable iff (!nrst)
    speed_sel_pins == 2'h3 [*4] ##1 r_reg.state == rbcs_pkg::RBCS_RUN && !power_down_req
      |=> clk_ctl.pll_ratio_readback == 2'h3 && clk_ctl.pll_enable)
    else $error("Times three not selected.");

  chk_sync_two_flops: assert property (@(posedge clk)
    !nrst |=> !rst_sync_reg)
    else $error("Internal reset not asserted at once.");

  chk_release_two_edges: assert property (@(posedge clk) disable iff (!nrst)
    $rose(nrst) |-> !rst_sync_reg ##1 !rst_sync_reg ##1 rst_sync_reg)
    else $error("Reset release not delayed by two edges.");

  chk_glitch_filtered: assert property (@(posedge clk) disable iff (!nrst)
    r_reg.speed_b != r_reg.speed_c |=> $stable(clk_ctl.pll_ratio_readback)
      && $stable(clk_ctl.pll_bypass_mode) && $stable(speed_reserved))
    else $error("Unsettled strap code reached the clock controls.");

  chk_reserved_no_clock: assert property (@(posedge clk) disable iff (!nrst)
    speed_reserved |-> !clk_ctl.clk_run && !clk_ctl.pll_enable)
    else $error("Clock running on the reserved speed code.");

  chk_pll_ratio_factor: assert property (@(posedge clk) disable iff (!nrst)
    clk_ctl.pll_enable |-> clk_ctl.pll_ratio_readback == 2'h2 || clk_ctl.pll_ratio_readback == 2'h3)
    else $error("Ratio readback not the multiply factor.");

  chk_pll_needs_run: assert property (@(posedge clk) disable iff (!nrst)
    clk_ctl.pll_enable |-> clk_ctl.clk_run)
    else $error("PLL enabled while the internal clock is off.");

  chk_down_holds_off: assert property (@(posedge clk) disable iff (!nrst)
    r_reg.state == rbcs_pkg::RBCS_DOWN |-> !clk_ctl.clk_run && !clk_ctl.pll_enable)
    else $error("Clock running while powered down.");

  chk_boot_one_cycle: assert property (@(posedge clk) disable iff (!nrst)
    boot_start |=> !boot_start)
    else $error("Boot start pulse longer than one cycle.");

  cov_boot: cover property (@(posedge clk) disable iff (!nrst) boot_start);
  cov_bypass: cover property (@(posedge clk) disable iff (!nrst) clk_ctl.pll_bypass_mode
    && clk_ctl.clk_run);
  cov_x2: cover property (@(posedge clk) disable iff (!nrst)
    clk_ctl.pll_ratio_readback == 2'h2 && clk_ctl.pll_enable);
  cov_down: cover property (@(posedge clk) disable iff (!nrst)
    r_reg.state == rbcs_pkg::RBCS_DOWN);
  cov_x3: cover property (@(posedge clk) disable iff (!nrst)
    clk_ctl.pll_ratio_readback == 2'h3 && clk_ctl.pll_enable);

endmodule // rbcs_top

/* File: dv/rbcs_board.sv */
// Board side model: global reset circuit and strap pins.
`timescale 1ns/1ps
module rbcs_board (
  // Clock and requests from the bench
  input  wire logic       clk,
  input  wire logic       rst_req,
  input  wire logic [1:0] strap,
  // Board pins
  output logic            nrst,
  output logic [1:0]      speed_sel_pins
);
  logic [3:0] hold_reg;
  logic [1:0] slow_div_reg;
  logic       slow_clock_in;
  initial begin
    hold_reg = 4'h0;
    slow_div_reg = 2'h0;
    slow_clock_in = 1'b0;
    nrst = 1'b0;
    speed_sel_pins = 2'h1;
  end
  always @(posedge clk) begin
    slow_div_reg <= slow_div_reg + 2'h1;
    if (slow_div_reg == 2'h3) slow_clock_in <= !slow_clock_in;
  end
  // Nine rising edges of the slow clock span at least eight whole periods of it.
  // reset held slow cycles
  always @(posedge clk) begin
    speed_sel_pins <= strap;
    if (rst_req) hold_reg <= 4'h9;
    else if (hold_reg != 4'h0 && slow_div_reg == 2'h3 && !slow_clock_in)
      hold_reg <= hold_reg - 4'h1;
    nrst <= !rst_req && hold_reg == 4'h0;
  end
endmodule // rbcs_board

/* File: dv/testbench.sv */
// Self-checking bench for the reset, boot and clock select block.
`timescale 1ns/1ps
module testbench;
  logic                    clk = 1'b0;
  logic                    rst_req = 1'b1;
  logic [1:0]              strap = 2'h1;
  logic                    power_down_req = 1'b0;
  logic                    nrst, sys_reset_n, boot_start, speed_reserved;
  logic [1:0]              speed_sel_pins;
  logic [31:0]             boot_fetch_addr;
  rbcs_pkg::rbcs_clk_ctl_t clk_ctl;
  int                      err_total = 0;
  int                      check_count = 0;
  int                      cyc = 0;
  int                      n;
  // Row: strap code, reserved flag, run, pll on, bypass, ratio.
  logic [7:0] rows [4] = '{8'h55, 8'h9A, 8'hDB, 8'h20};
  // The block counts edges only, so the bench period need not match the positioning reference.
  // reference clock stand-in
  always #20 clk = ~clk;
  rbcs_board board (.clk(clk), .rst_req(rst_req), .strap(strap), .nrst(nrst),
                    .speed_sel_pins(speed_sel_pins));
  rbcs_top dut (.clk(clk), .nrst(nrst), .speed_sel_pins(speed_sel_pins),
                .power_down_req(power_down_req), .sys_reset_n(sys_reset_n),
                .boot_start(boot_start), .boot_fetch_addr(boot_fetch_addr),
                .clk_ctl(clk_ctl), .speed_reserved(speed_reserved));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic boot(input logic [1:0] code);
    @(posedge clk);
    strap <= code;
    rst_req <= 1'b1;
    repeat (5) @(negedge clk);
    check(32'({sys_reset_n, boot_start, speed_reserved, clk_ctl}), 32'h0);
    @(posedge clk);
    rst_req <= 1'b0;
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      tally_and_finish();
    end
  end
  initial begin
    for (int i = 0; i < 4; i++) begin
      boot(rows[i][7:6]);
      repeat (100) @(negedge clk);
      check(32'({speed_reserved, clk_ctl}), 32'(rows[i][5:0]));
    end
    // Release timing: the boot pulse must wait for the synchroniser.
    boot(2'h2);
    n = 0;
    while (nrst !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (boot_start !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    check(32'(n), 32'(3 + rbcs_pkg::INIT_CYCLES));
    check(32'(sys_reset_n), 32'h1);
    check(boot_fetch_addr, 32'h07FFFFFE);
    @(negedge clk);
    check(32'(boot_start), 32'h0);
    @(posedge clk);
    power_down_req <= 1'b1;
    repeat (3) @(negedge clk);
    check(32'({clk_ctl.clk_run, clk_ctl.pll_enable}), 32'h0);
    @(posedge clk);
    power_down_req <= 1'b0;
    repeat (5) @(negedge clk);
    check(32'(clk_ctl), 32'h1A);
    // A one-cycle strap glitch must never reach the clock controls.
    @(posedge clk);
    strap <= 2'h0;
    @(posedge clk);
    strap <= 2'h2;
    repeat (6) begin
      @(negedge clk);
      check(32'({speed_reserved, clk_ctl}), 32'h1A);
    end
    tally_and_finish();
  end
endmodule // testbench
